// ---- include/sdl_pkg.sv ----
// Shared constants for the steered converter load bus: decoded bus
// addresses, steering byte layout, latch indices and host register map.
// Assumes both ends of the parallel bus run on the same clock.
`default_nettype none

package sdl_pkg;

	// Decoded addresses on the parallel bus
	localparam logic [7:0] ADDR_STEER = 8'h70;
	localparam logic [7:0] ADDR_DATA = 8'h71;
	localparam logic [7:0] ADDR_WRITE_BACK = 8'h80;

	// Steering byte: hold selects and per-latch select lines (low enables)
	localparam int FINE_HOLD_POS = 0;
	localparam int COARSE_HOLD_POS = 7;
	localparam int NUM_LATCHES = 6;
	localparam logic [7:0] STEER_RESET = 8'h7e;

	// Latch indices; the select line of latch i is steering bit i+1
	localparam int LAT_COARSE_LOW = 0;
	localparam int LAT_COARSE_HIGH = 1;
	localparam int LAT_FINE_HIGH = 2;
	localparam int LAT_FINE_LOW = 3;
	localparam int LAT_COARSE_MID = 4;
	localparam int LAT_FINE_MID = 5;
	localparam logic [7:0] LATCH_RESET = 8'h00;

	// Converter word split: the middle byte gives four bits to each word
	localparam int WORD_W = 12;
	localparam int MID_SPLIT = 4;

	// Host bus query length in clock cycles and bytes per load
	localparam int QUERY_CYCLES = 4;
	localparam int LOAD_BYTES = 7;

	// Host register map (AXI4-Lite byte addresses)
	localparam logic [7:0] REG_STEER = 8'h00;
	localparam logic [7:0] REG_DATA = 8'h04;
	localparam logic [7:0] REG_QUERY = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;

	// Status word fields
	localparam int ST_BUSY = 0;
	localparam int ST_MATCH = 1;
	localparam int ST_COUNT_LSB = 4;
	localparam int ST_LOAD_DONE = 8;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : sdl_pkg

`default_nettype wire

// ---- include/sdl_bus_if.sv ----
// Parallel address/data bus between the microcomputer end and the
// converter control logic. Bit 7 of the data line is open-drain from the
// device during a write-back query; it is resolved here.
`timescale 1ns/1ps
`default_nettype none

interface sdl_bus_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr_n;
	logic rd_n;
	logic d7_o;
	logic d7_oe_n;
	logic d7;

	// Pulled up when the device releases the line
	assign d7 = d7_oe_n ? 1'b1 : d7_o;

	modport dev (
		input addr,
		input wdata,
		input wr_n,
		input rd_n,
		output d7_o,
		output d7_oe_n
	);

	modport host (
		output addr,
		output wdata,
		output wr_n,
		output rd_n,
		input d7
	);
endinterface : sdl_bus_if

`default_nettype wire

// ---- src/sdl_dev.sv ----
// Converter control logic: steering register, six byte storage latches,
// hold/track selects and the write-back open-drain answer on data bit 7.
// Assumes the bus master runs on mclk_in and holds address and data
// stable around each one-cycle write strobe.
//
// Operation
// - Steering byte written at address 70
// - Data latched when select and strobe low
// - Host delivers seven bytes per load
// - Address 80 enables both write-back comparisons
// - Six steering lines select storage latches
// - Bits one and eight set hold/track
// - Coarse hold bit high holds, low tracks
// - Two sets of three storage latches
// - Low, high and shared middle byte mapping
// - Host rewrites latches for new voltage
// - Steering 00 enables all, both track
// - Data 00 zeroes every converter position
// - Data FF sets every converter position
// - Mid-range: zero, steer 33, data 80
// - Mismatch during write-back pulls bit 7 low
`timescale 1ns/1ps
`default_nettype none

module sdl_dev (
	// Clock, reset, enable
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// Parallel bus
	sdl_bus_if.dev bus,
	// Comparator results, high when stored and approximated values differ
	input wire logic coarse_mismatch_in,
	input wire logic fine_mismatch_in,
	// Track/hold selects, high for hold
	output logic coarse_hold_out,
	output logic fine_hold_out,
	// Write-back comparator enables
	output logic coarse_wb_en_out,
	output logic fine_wb_en_out,
	// Converter words
	output logic [sdl_pkg::WORD_W-1:0] coarse_hi_word_out,
	output logic [sdl_pkg::WORD_W-1:0] coarse_lo_word_out,
	output logic [sdl_pkg::WORD_W-1:0] fine_hi_word_out,
	output logic [sdl_pkg::WORD_W-1:0] fine_lo_word_out
);

	logic [7:0] steer_q;
	logic [7:0] latch_q [sdl_pkg::NUM_LATCHES];
	logic wb_pull_q;
	logic wb_en_q;
	logic [1:0] mm_meta_q;
	logic [1:0] mm_sync_q;
	logic steer_wr;
	logic data_wr;
	logic wb_sel;

	// Upper bits of a converter word: the full high byte plus the top of the middle byte
	function automatic logic [sdl_pkg::WORD_W-1:0] hi_word(input logic [7:0] hi, input logic [7:0] mid);
		hi_word = {hi, mid[7:sdl_pkg::MID_SPLIT]};
	endfunction : hi_word

	// Lower word: bottom of the middle byte plus the full low byte
	function automatic logic [sdl_pkg::WORD_W-1:0] lo_word(input logic [7:0] mid, input logic [7:0] lo);
		lo_word = {mid[sdl_pkg::MID_SPLIT-1:0], lo};
	endfunction : lo_word

	// Select line of a latch, active low
	function automatic logic latch_selected(input logic [7:0] steer, input int idx);
		latch_selected = !steer[idx + 1];
	endfunction : latch_selected

	assign steer_wr = !bus.wr_n && (bus.addr == sdl_pkg::ADDR_STEER);
	assign data_wr = !bus.wr_n && (bus.addr == sdl_pkg::ADDR_DATA);
	assign wb_sel = !bus.rd_n && (bus.addr == sdl_pkg::ADDR_WRITE_BACK);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			steer_q <= sdl_pkg::STEER_RESET;
		end else if (ce_in) begin
			if (steer_wr) begin
				steer_q <= bus.wdata;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < sdl_pkg::NUM_LATCHES; i++) begin
				latch_q[i] <= sdl_pkg::LATCH_RESET;
			end
		end else if (ce_in) begin
			for (int i = 0; i < sdl_pkg::NUM_LATCHES; i++) begin
				if (data_wr && latch_selected(steer_q, i)) begin
					latch_q[i] <= bus.wdata;
				end
			end
		end
	end

	assign coarse_hold_out = steer_q[sdl_pkg::COARSE_HOLD_POS];
	assign fine_hold_out = steer_q[sdl_pkg::FINE_HOLD_POS];

	assign coarse_hi_word_out = hi_word(latch_q[sdl_pkg::LAT_COARSE_HIGH], latch_q[sdl_pkg::LAT_COARSE_MID]);
	assign coarse_lo_word_out = lo_word(latch_q[sdl_pkg::LAT_COARSE_MID], latch_q[sdl_pkg::LAT_COARSE_LOW]);
	assign fine_hi_word_out = hi_word(latch_q[sdl_pkg::LAT_FINE_HIGH], latch_q[sdl_pkg::LAT_FINE_MID]);
	assign fine_lo_word_out = lo_word(latch_q[sdl_pkg::LAT_FINE_MID], latch_q[sdl_pkg::LAT_FINE_LOW]);

	// Registered so the comparator is enabled one cycle before the line pull can start
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			wb_en_q <= 1'b0;
		end else if (ce_in) begin
			wb_en_q <= wb_sel;
		end
	end

	assign coarse_wb_en_out = wb_en_q;
	assign fine_wb_en_out = wb_en_q;

	// Comparator outputs are analog and unclocked: two flops before any use
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			mm_meta_q <= 2'h0;
			mm_sync_q <= 2'h0;
		end else if (ce_in) begin
			mm_meta_q <= {coarse_mismatch_in, fine_mismatch_in};
			mm_sync_q <= mm_meta_q;
		end
	end

	// Only an enabled comparator may pull; the line floats high otherwise
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			wb_pull_q <= 1'b0;
		end else if (ce_in) begin
			wb_pull_q <= wb_en_q && wb_sel && (|mm_sync_q);
		end
	end

	// Open drain: the value is always low, the enable decides
	assign bus.d7_o = 1'b0;
	assign bus.d7_oe_n = !wb_pull_q;

endmodule : sdl_dev

`default_nettype wire

// ---- src/sdl_host.sv ----
// Microcomputer end of the load bus: takes byte writes and write-back
// queries from software over AXI4-Lite and plays them onto the parallel
// bus, one operation at a time.
// Assumes the device samples the bus on the same mclk_in edges.
`timescale 1ns/1ps
`default_nettype none

module sdl_host (
	// Clock, reset, enable
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Parallel bus
	sdl_bus_if.host bus
);

	typedef enum logic [2:0] {
		SDL_IDLE,
		SDL_SETUP,
		SDL_STROBE,
		SDL_RELEASE,
		SDL_QUERY
	} sdl_state_e;

	sdl_state_e state_q;
	logic aw_q;
	logic w_q;
	logic [7:0] awaddr_q;
	logic [7:0] wbyte_q;
	logic [7:0] addr_q;
	logic [7:0] data_q;
	logic [7:0] last_steer_q;
	logic [7:0] last_data_q;
	logic [2:0] qcnt_q;
	logic [2:0] bytes_q;
	logic match_q;
	logic go_wr;
	logic known_wr;

	assign s_axi_awready = !aw_q;
	assign s_axi_wready = !w_q;
	// Writes wait here while the bus is busy, stalling software
	assign go_wr = aw_q && w_q && !s_axi_bvalid && (state_q == SDL_IDLE);
	assign known_wr = (awaddr_q == sdl_pkg::REG_STEER) || (awaddr_q == sdl_pkg::REG_DATA)
		|| (awaddr_q == sdl_pkg::REG_QUERY);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wbyte_q <= 8'h00;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= sdl_pkg::RESP_OKAY;
		end else if (ce_in) begin
			if (s_axi_awvalid && !aw_q) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_q) begin
				w_q <= 1'b1;
				wbyte_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
			end
			if (go_wr) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= known_wr ? sdl_pkg::RESP_OKAY : sdl_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Bus sequencer: setup, one-cycle strobe, release
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			state_q <= SDL_IDLE;
			addr_q <= 8'h00;
			data_q <= 8'h00;
			qcnt_q <= 3'h0;
		end else if (ce_in) begin
			case (state_q)
				SDL_IDLE: begin
					if (go_wr && awaddr_q == sdl_pkg::REG_STEER) begin
						addr_q <= sdl_pkg::ADDR_STEER;
						data_q <= wbyte_q;
						state_q <= SDL_SETUP;
					end else if (go_wr && awaddr_q == sdl_pkg::REG_DATA) begin
						addr_q <= sdl_pkg::ADDR_DATA;
						data_q <= wbyte_q;
						state_q <= SDL_SETUP;
					end else if (go_wr && awaddr_q == sdl_pkg::REG_QUERY) begin
						addr_q <= sdl_pkg::ADDR_WRITE_BACK;
						qcnt_q <= 3'(sdl_pkg::QUERY_CYCLES - 1);
						state_q <= SDL_QUERY;
					end
				end
				SDL_SETUP: state_q <= SDL_STROBE;
				SDL_STROBE: state_q <= SDL_RELEASE;
				SDL_RELEASE: state_q <= SDL_IDLE;
				SDL_QUERY: begin
					if (qcnt_q == 3'h0) begin
						state_q <= SDL_IDLE;
					end else begin
						qcnt_q <= qcnt_q - 3'h1;
					end
				end
				default: state_q <= SDL_IDLE;
			endcase
		end
	end

	assign bus.addr = addr_q;
	assign bus.wdata = data_q;
	assign bus.wr_n = (state_q != SDL_STROBE);
	assign bus.rd_n = (state_q != SDL_QUERY);

	// Answer sampled in the last query cycle; line high means match
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			match_q <= 1'b1;
		end else if (ce_in && state_q == SDL_QUERY && qcnt_q == 3'h0) begin
			match_q <= bus.d7;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			bytes_q <= 3'h0;
			last_steer_q <= 8'h00;
			last_data_q <= 8'h00;
		end else if (ce_in && state_q == SDL_STROBE) begin
			if (addr_q == sdl_pkg::ADDR_STEER) begin
				bytes_q <= 3'h1;
				last_steer_q <= data_q;
			end else if (addr_q == sdl_pkg::ADDR_DATA) begin
				last_data_q <= data_q;
				if (bytes_q != 3'(sdl_pkg::LOAD_BYTES)) begin
					bytes_q <= bytes_q + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= sdl_pkg::RESP_OKAY;
		end else if (ce_in) begin
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= sdl_pkg::RESP_OKAY;
				case (s_axi_araddr)
					sdl_pkg::REG_STEER: s_axi_rdata <= {24'h000000, last_steer_q};
					sdl_pkg::REG_DATA: s_axi_rdata <= {24'h000000, last_data_q};
					sdl_pkg::REG_QUERY: s_axi_rdata <= 32'h0000_0000;
					sdl_pkg::REG_STATUS: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rdata[sdl_pkg::ST_BUSY] <= (state_q != SDL_IDLE) || aw_q || w_q;
						s_axi_rdata[sdl_pkg::ST_MATCH] <= match_q;
						s_axi_rdata[sdl_pkg::ST_COUNT_LSB +: 3] <= bytes_q;
						s_axi_rdata[sdl_pkg::ST_LOAD_DONE] <= (bytes_q == 3'(sdl_pkg::LOAD_BYTES));
					end
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= sdl_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

endmodule : sdl_host

`default_nettype wire

// ---- dv/sdl_monitor.sv ----
// Checker for the load bus and the device outputs.
// Assumes one clock; placed beside the bus interface by the bench.
`timescale 1ns/1ps
`default_nettype none
module sdl_monitor (
	// Clock, reset, bus
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic d7_oe_n,
	// Device side
	input wire logic coarse_mismatch_in,
	input wire logic fine_mismatch_in,
	input wire logic coarse_hold_out,
	input wire logic fine_hold_out,
	input wire logic coarse_wb_en_out,
	input wire logic fine_wb_en_out,
	input wire logic [sdl_pkg::WORD_W-1:0] coarse_hi_word_out,
	input wire logic [sdl_pkg::WORD_W-1:0] fine_lo_word_out
);
	logic [7:0] steer_q;
	logic [1:0] mm_d1_q;
	logic [1:0] mm_d2_q;
	wire logic st_w = !wr_n && addr == sdl_pkg::ADDR_STEER;
	wire logic dt_w = !wr_n && addr == sdl_pkg::ADDR_DATA;
	// Pull only while the query strobe stands and the synchronised mismatch is seen
	wire logic pull_w = coarse_wb_en_out && !rd_n && addr == sdl_pkg::ADDR_WRITE_BACK && (|mm_d2_q);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (sys_rst_in);
	// Shadow of the steering byte, so latch selects can be judged
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in)
			steer_q <= sdl_pkg::STEER_RESET;
		else if (st_w)
			steer_q <= wdata;
	end
	// Comparator results pass a two-stage synchroniser in the device
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			mm_d1_q <= 2'h0;
			mm_d2_q <= 2'h0;
		end else begin
			mm_d1_q <= {coarse_mismatch_in, fine_mismatch_in};
			mm_d2_q <= mm_d1_q;
		end
	end
	sequence query_s;
		$fell(rd_n) && addr == sdl_pkg::ADDR_WRITE_BACK;
	endsequence
	sequence query_len_s;
		!rd_n [*3] ##1 rd_n;
	endsequence
	steer_load_a: assert property (
		st_w |=> coarse_hold_out == $past(wdata[7]) && fine_hold_out == $past(wdata[0]))
		else $error("hold selects differ from steering byte");
	hold_keep_a: assert property (!st_w |=> $stable({coarse_hold_out, fine_hold_out}))
		else $error("hold selects moved without steering write");
	hi_load_a: assert property (
		dt_w && !steer_q[2] |=> coarse_hi_word_out[11:4] == $past(wdata))
		else $error("selected high latch not loaded");
	hi_keep_a: assert property (
		!(dt_w && !steer_q[2]) |=> $stable(coarse_hi_word_out[11:4]))
		else $error("unselected high latch changed");
	flo_load_a: assert property (
		dt_w && !steer_q[4] |=> fine_lo_word_out[7:0] == $past(wdata))
		else $error("selected low latch not loaded");
	query_len_a: assert property (query_s |=> query_len_s)
		else $error("query strobe length wrong");
	wb_enable_a: assert property (query_s |=> fine_wb_en_out [*4] ##1 !fine_wb_en_out)
		else $error("write-back enable does not follow query");
	wb_pair_a: assert property (coarse_wb_en_out == fine_wb_en_out)
		else $error("write-back enables differ");
	wb_pull_a: assert property (pull_w |=> !d7_oe_n)
		else $error("mismatch did not pull bit 7");
	wb_release_a: assert property (!pull_w |=> d7_oe_n)
		else $error("bit 7 pulled without queried mismatch");
endmodule : sdl_monitor
`default_nettype wire

// ---- dv/steered_dac_load_track_hold_tb_top.sv ----
// Bench: an AXI4-Lite master drives the host end, which drives the
// device end over the shared bus. Assumes the package register map.
`timescale 1ns/1ps
`default_nettype none
module steered_dac_load_track_hold_tb_top;
	logic mclk_in = 1'h0;
	logic sys_rst_in = 1'h1;
	logic cm = 1'h0, fm = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, ch, fh, cwb, fwb;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [11:0] chw, clw, fhw, flw;
	int err_count = 0;
	int n_checks = 0;
	sdl_bus_if bus_if ();
	sdl_dev sdl_dev_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(1'h1), .bus(bus_if.dev),
		.coarse_mismatch_in(cm), .fine_mismatch_in(fm), .coarse_hold_out(ch), .fine_hold_out(fh),
		.coarse_wb_en_out(cwb), .fine_wb_en_out(fwb), .coarse_hi_word_out(chw), .coarse_lo_word_out(clw),
		.fine_hi_word_out(fhw), .fine_lo_word_out(flw));
	sdl_host sdl_host_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(1'h1), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus(bus_if.host));
	sdl_monitor sdl_monitor_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr(bus_if.addr),
		.wdata(bus_if.wdata), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n), .d7_oe_n(bus_if.d7_oe_n),
		.coarse_mismatch_in(cm), .fine_mismatch_in(fm), .coarse_hold_out(ch), .fine_hold_out(fh),
		.coarse_wb_en_out(cwb), .fine_wb_en_out(fwb), .coarse_hi_word_out(chw), .fine_lo_word_out(flw));
	initial begin
		forever #50 mclk_in = ~mclk_in;
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		int i;
		@(posedge mclk_in);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (i = 0; i < 40; i++) begin
			@(posedge mclk_in);
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
			if (bvalid)
				break;
		end
		bready <= 1'h0;
		r = bresp;
		if (i == 40) begin
			chk("write response wait", 32'h1, 32'h0);
			end_sim();
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge mclk_in);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (i = 0; i < 40; i++) begin
			@(posedge mclk_in);
			if (arvalid && arready)
				arvalid <= 1'h0;
			if (rvalid)
				break;
		end
		rready <= 1'h0;
		d = rdata;
		r = rresp;
		if (i == 40) begin
			chk("read response wait", 32'h1, 32'h0);
			end_sim();
		end
	endtask : axi_rd
	// Bus operations outlive the write response, so poll busy before looking
	task automatic put(input logic [7:0] a, input logic [7:0] v);
		logic [31:0] d;
		logic [1:0] r;
		int k;
		axi_wr(a, v, r);
		for (k = 0; k < 20; k++) begin
			axi_rd(sdl_pkg::REG_STATUS, d, r);
			if (d[sdl_pkg::ST_BUSY] === 1'h0)
				break;
		end
		if (k == 20) begin
			chk("bus idle wait", 32'h1, 32'h0);
			end_sim();
		end
	endtask : put
	task automatic words(input logic [11:0] a, input logic [11:0] b, input logic [11:0] c, input logic [11:0] e);
		chk("coarse high word", 32'(chw), 32'(a));
		chk("coarse low word", 32'(clw), 32'(b));
		chk("fine high word", 32'(fhw), 32'(c));
		chk("fine low word", 32'(flw), 32'(e));
	endtask : words
	task automatic t_full;
		logic [7:0] d;
		for (int i = 0; i < 2; i++) begin
			d = i ? 8'h00 : 8'hff;
			put(sdl_pkg::REG_STEER, 8'h00);
			put(sdl_pkg::REG_DATA, d);
			words({d, d[7:4]}, {d[3:0], d}, {d, d[7:4]}, {d[3:0], d});
			chk("hold selects", 32'({ch, fh}), 32'h0);
		end
		$display("done: full range points");
	endtask : t_full
	task automatic t_map;
		for (int i = 0; i < 6; i++) begin
			put(sdl_pkg::REG_STEER, ~(8'h02 << i));
			put(sdl_pkg::REG_DATA, 8'(8'h11 * (i + 1)));
		end
		words(12'h225, 12'h511, 12'h336, 12'h644);
		chk("hold selects", 32'({ch, fh}), 32'h3);
		$display("done: one latch at a time");
	endtask : t_map
	task automatic t_load;
		logic [31:0] d;
		logic [1:0] r;
		put(sdl_pkg::REG_STEER, 8'h7b);
		for (int i = 0; i < 6; i++)
			put(sdl_pkg::REG_DATA, 8'(8'h10 + i));
		axi_rd(sdl_pkg::REG_STATUS, d, r);
		chk("load done", 32'(d[sdl_pkg::ST_LOAD_DONE]), 32'h1);
		chk("load byte count", 32'(d[sdl_pkg::ST_COUNT_LSB +: 3]), 32'(sdl_pkg::LOAD_BYTES));
		words(12'h155, 12'h511, 12'h336, 12'h644);
		chk("hold selects", 32'({ch, fh}), 32'h1);
		$display("done: seven byte load");
	endtask : t_load
	task automatic t_mid;
		put(sdl_pkg::REG_STEER, 8'h00);
		put(sdl_pkg::REG_DATA, 8'h00);
		put(sdl_pkg::REG_STEER, 8'h33);
		put(sdl_pkg::REG_DATA, 8'h80);
		words(12'h800, 12'h000, 12'h808, 12'h000);
		$display("done: mid range");
	endtask : t_mid
	task automatic t_query;
		logic [31:0] d;
		logic [1:0] r;
		for (int k = 0; k < 3; k++) begin
			@(posedge mclk_in);
			{cm, fm} <= 2'(k);
			put(sdl_pkg::REG_QUERY, 8'h00);
			axi_rd(sdl_pkg::REG_STATUS, d, r);
			chk("match flag", 32'(d[sdl_pkg::ST_MATCH]), 32'(k == 0));
		end
		chk("bit 7 line", 32'(bus_if.d7), 32'h1);
		@(posedge mclk_in);
		{cm, fm} <= 2'h0;
		$display("done: write-back queries");
	endtask : t_query
	task automatic t_refuse;
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(8'h10, 8'h5a, r);
		chk("unmapped write response", 32'(r), 32'(sdl_pkg::RESP_SLVERR));
		axi_rd(8'h10, d, r);
		chk("unmapped read response", 32'(r), 32'(sdl_pkg::RESP_SLVERR));
		chk("unmapped read data", d, 32'h0);
		axi_rd(sdl_pkg::REG_STEER, d, r);
		chk("steering readback", d, 32'h33);
		axi_rd(sdl_pkg::REG_DATA, d, r);
		chk("data readback", d, 32'h80);
		words(12'h800, 12'h000, 12'h808, 12'h000);
		$display("done: refused accesses");
	endtask : t_refuse
	initial begin
		repeat (4) @(posedge mclk_in);
		sys_rst_in <= 1'h0;
		chk("hold selects", 32'({ch, fh}), 32'h0);
		chk("bit 7 line", 32'(bus_if.d7), 32'h1);
		t_full();
		t_map();
		t_load();
		t_mid();
		t_query();
		t_refuse();
		end_sim();
	end
endmodule : steered_dac_load_track_hold_tb_top
`default_nettype wire
